// file: rtl/rm_consts.svh
`ifndef RM_CONSTS_SVH
`define RM_CONSTS_SVH

// ****************************************************************
// Frame and control word fields
// ****************************************************************
`define RM_FRAME_BITS     24
`define RM_BIT_REG_SEL    0
`define RM_BIT_MON_LO     18
`define RM_BIT_MON_HI     19
`define RM_BIT_REC_DIS    20
`define RM_BIT_DUTY       21
`define RM_BIT_STAT_RST   22
`define RM_BIT_ENABLE     23
`define RM_CTRL_RESET     24'h000000

// ****************************************************************
// Status word fields
// ****************************************************************
`define RM_ST_NO_ERR      0
`define RM_ST_NOT_READY   18
`define RM_ST_TW          19
`define RM_ST_TSD         20
`define RM_ST_UV          21
`define RM_ST_OV          22
`define RM_ST_ALWAYS_ONE  23

// ****************************************************************
// Timing
// ****************************************************************
`define RM_CLK_HZ         40000000
`define RM_STARTUP_NS     10000
`define RM_STARTUP_CYC    ((`RM_STARTUP_NS * (`RM_CLK_HZ / 1000000) + 999) / 1000)

`endif

// file: rtl/rm_pkg.sv
package rm_pkg;

    // Monitor routing, coded as {bit 19, bit 18}
    typedef enum logic [1:0] {
        RM_MON_HIGH_SIDE_HEAVY = 2'h0,
        RM_MON_HIGH_SIDE_A     = 2'h1,
        RM_MON_HALF_BRIDGE_ONE = 2'h2,
        RM_MON_HIGH_SIDE_B     = 2'h3
    } rm_mon_sel_e;

    typedef struct packed {
        logic sclk;
        logic select_low;
        logic di;
    } rm_spi_in_s;

    typedef struct packed {
        logic ov;
        logic uv;
        logic thermal_shutdown_flag;
        logic tw;
    } rm_fault_s;

    typedef struct packed {
        logic        busy;
        logic [15:0] cnt;
    } rm_timer_s;

    typedef struct packed {
        logic [1:0]  sclk_s;
        logic [1:0]  csn_s;
        logic [1:0]  di_s;
        rm_fault_s   ev_s0;
        rm_fault_s   ev_s1;
        logic        sclk_q;
        logic        csn_q;
        logic        loaded;
        logic [4:0]  bit_cnt;
        logic [23:0] shift_in;
        logic [23:0] shift_out;
        logic [23:0] ctrl;
        rm_fault_s   flags;
        logic        active_q;
        logic        spi_do;
        logic        spi_do_oe;
        logic        outputs_enable;
    } rm_core_s;

endpackage : rm_pkg

// file: rtl/rm_startup_timer.sv
`include "rm_consts.svh"

module rm_startup_timer #(
    parameter int STARTUP_CYCLES = `RM_STARTUP_CYC
) (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic run,
    input  wire logic start,
    output logic      busy
);
    import rm_pkg::*;

    rm_timer_s s;
    rm_timer_s next_s;

    always_comb begin
        next_s = s;
        if (!run) begin
            next_s.busy = 1'b0;
        end else if (start) begin
            next_s.busy = 1'b1;
            next_s.cnt  = 16'(STARTUP_CYCLES - 1);
        end else if (s.busy) begin
            if (s.cnt == 16'h0000) begin
                next_s.busy = 1'b0;
            end else begin
                next_s.cnt = s.cnt - 16'h0001;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign busy = s.busy;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_timer_ends;
        @(posedge core_clk) disable iff (rst)
        run && !start && s.busy && s.cnt == 16'h0000 |=> !busy;
    endproperty
    a_timer_ends: assert property (p_timer_ends)
        else $error("startup timer did not end at zero");

    property p_timer_counts;
        @(posedge core_clk) disable iff (rst)
        run && !start && s.busy && s.cnt != 16'h0000
            |=> busy && s.cnt == $past(s.cnt) - 16'h0001;
    endproperty
    a_timer_counts: assert property (p_timer_counts)
        else $error("startup timer did not count down");

endmodule : rm_startup_timer

// file: rtl/rm_recovery_monitor.sv
`include "rm_consts.svh"

module rm_recovery_monitor #(
    parameter int STARTUP_CYCLES = `RM_STARTUP_CYC
) (
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire rm_pkg::rm_spi_in_s  spi_in,
    input  wire rm_pkg::rm_fault_s   fault_in,
    output logic                     spi_do,
    output logic                     spi_do_oe,
    output logic                     outputs_enable,
    output logic                     active_mode,
    output logic                     not_ready,
    output rm_pkg::rm_mon_sel_e      monitor_sel,
    output logic                     oc_recovery_duty,
    output rm_pkg::rm_fault_s        fault_flags
);
    import rm_pkg::*;

    rm_core_s s;
    rm_core_s next_s;
    logic     sclk_rise;
    logic     sclk_fall;
    logic     csn_fall;
    logic     frame_ok;
    logic     wr_ctrl;
    logic     clr_stat;
    logic     tmr_start;
    logic     timer_busy;
    logic [23:0] stat_now;

    // Status word 0 image; bit 0 is the NOR of bits 1 to 22
    function automatic logic [23:0] status_word(input rm_fault_s f,
                                                input logic nrdy);
        logic [23:0] w;
        w                    = 24'h000000;
        w[`RM_ST_ALWAYS_ONE] = 1'b1;
        w[`RM_ST_OV]         = f.ov;
        w[`RM_ST_UV]         = f.uv;
        w[`RM_ST_TSD]        = f.thermal_shutdown_flag;
        w[`RM_ST_TW]         = f.tw;
        w[`RM_ST_NOT_READY]  = nrdy;
        w[`RM_ST_NO_ERR]     = ~|w[22:1];
        return w;
    endfunction : status_word

    // ****************************************************************
    // Start-up timer
    // ****************************************************************
    rm_startup_timer #(
        .STARTUP_CYCLES (STARTUP_CYCLES)
    ) u_timer (
        .core_clk (core_clk),
        .rst      (rst),
        .run      (s.ctrl[`RM_BIT_ENABLE]),
        .start    (tmr_start),
        .busy     (timer_busy)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_s = s;

        // Pin synchronisers
        next_s.sclk_s = {s.sclk_s[0], spi_in.sclk};
        next_s.csn_s  = {s.csn_s[0], spi_in.select_low};
        next_s.di_s   = {s.di_s[0], spi_in.di};
        next_s.ev_s0  = fault_in;
        next_s.ev_s1  = s.ev_s0;
        next_s.sclk_q = s.sclk_s[1];
        next_s.csn_q  = s.csn_s[1];

        sclk_rise = s.sclk_s[1] & ~s.sclk_q & ~s.csn_s[1];
        sclk_fall = ~s.sclk_s[1] & s.sclk_q & ~s.csn_s[1];
        csn_fall  = ~s.csn_s[1] & s.csn_q;
        frame_ok  = s.csn_s[1] & ~s.csn_q
                  & (s.bit_cnt == 5'(`RM_FRAME_BITS));
        wr_ctrl   = frame_ok & ~s.shift_in[`RM_BIT_REG_SEL];
        clr_stat  = frame_ok & s.shift_in[`RM_BIT_STAT_RST];
        tmr_start = s.ctrl[`RM_BIT_ENABLE] & ~s.active_q;
        stat_now  = status_word(s.flags, timer_busy);

        // ************************************************************
        // Serial frame
        // ************************************************************
        if (csn_fall) begin
            next_s.bit_cnt = 5'h00;
            next_s.loaded  = 1'b0;
        end
        if (sclk_rise) begin
            next_s.shift_in = {s.di_s[1], s.shift_in[23:1]};
            if (s.bit_cnt != 5'h1f) begin
                next_s.bit_cnt = s.bit_cnt + 5'h01;
            end
            if (!s.loaded) begin
                next_s.shift_out = stat_now;
                next_s.loaded    = 1'b1;
            end
        end
        if (sclk_fall && s.loaded) begin
            next_s.shift_out = {1'b0, s.shift_out[23:1]};
        end
        next_s.spi_do_oe = ~s.csn_s[1];
        next_s.spi_do    = next_s.loaded ? next_s.shift_out[0]
                         : stat_now[`RM_ST_NO_ERR];

        // ************************************************************
        // Control word
        // ************************************************************
        if (wr_ctrl) begin
            next_s.ctrl = s.shift_in;
        end
        next_s.active_q = s.ctrl[`RM_BIT_ENABLE];

        // ************************************************************
        // Sticky faults: set wins over clear, standby clears all
        // ************************************************************
        if (clr_stat || !s.ctrl[`RM_BIT_ENABLE]) begin
            next_s.flags = '0;
        end
        if (s.ctrl[`RM_BIT_ENABLE]) begin
            next_s.flags = next_s.flags | s.ev_s1;
        end

        // ************************************************************
        // Output permission
        // ************************************************************
        next_s.outputs_enable = s.ctrl[`RM_BIT_ENABLE] & s.active_q
            & ~timer_busy
            & ~s.flags.thermal_shutdown_flag & ~s.ev_s1.thermal_shutdown_flag
            & ~s.ev_s1.ov & ~s.ev_s1.uv
            & ~(s.ctrl[`RM_BIT_REC_DIS]
                & (s.flags.ov | s.flags.uv));
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            // Select synchroniser rests at the idle (high) pin level
            s       <= '0;
            s.csn_s <= 2'h3;
            s.csn_q <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign spi_do           = s.spi_do;
    assign spi_do_oe        = s.spi_do_oe;
    assign outputs_enable   = s.outputs_enable;
    assign active_mode      = s.ctrl[`RM_BIT_ENABLE];
    assign not_ready        = timer_busy;
    assign monitor_sel      = rm_mon_sel_e'(s.ctrl[`RM_BIT_MON_HI:
                                                  `RM_BIT_MON_LO]);
    assign oc_recovery_duty = s.ctrl[`RM_BIT_DUTY];
    assign fault_flags      = s.flags;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_uv_auto_recover;
        @(posedge core_clk) disable iff (rst)
        active_mode && s.active_q && !not_ready && fault_flags.thermal_shutdown_flag == 1'b0
            && !(s.ctrl[`RM_BIT_REC_DIS] && (fault_flags.ov || fault_flags.uv))
            && s.ev_s1 == '0 |=> outputs_enable;
    endproperty
    a_uv_auto_recover: assert property (p_uv_auto_recover)
        else $error("outputs not restored after supply recovery");

    property p_tsd_off;
        @(posedge core_clk) disable iff (rst)
        fault_flags.thermal_shutdown_flag |=> !outputs_enable;
    endproperty
    a_tsd_off: assert property (p_tsd_off)
        else $error("outputs on during thermal shutdown");

    property p_tw_held;
        @(posedge core_clk) disable iff (rst)
        fault_flags.tw && !clr_stat && active_mode |=> fault_flags.tw;
    endproperty
    a_tw_held: assert property (p_tw_held)
        else $error("temperature warning lost without clear");

    property p_start_not_ready;
        @(posedge core_clk) disable iff (rst)
        tmr_start |=> not_ready ##1 !outputs_enable;
    endproperty
    a_start_not_ready: assert property (p_start_not_ready)
        else $error("not-ready not raised on activation");

    property p_ready_enables;
        @(posedge core_clk) disable iff (rst)
        $fell(not_ready) && active_mode && fault_flags == '0
            && s.ev_s1 == '0 |=> outputs_enable;
    endproperty
    a_ready_enables: assert property (p_ready_enables)
        else $error("outputs not enabled after start-up");

    property p_mon_sel;
        @(posedge core_clk) disable iff (rst)
        wr_ctrl |=> monitor_sel == rm_mon_sel_e'($past(s.shift_in[19:18]));
    endproperty
    a_mon_sel: assert property (p_mon_sel)
        else $error("monitor select not taken from frame");

    property p_duty;
        @(posedge core_clk) disable iff (rst)
        wr_ctrl |=> oc_recovery_duty == $past(s.shift_in[21]);
    endproperty
    a_duty: assert property (p_duty)
        else $error("recovery duty bit not taken from frame");

    property p_uv_flag;
        @(posedge core_clk) disable iff (rst)
        s.ev_s1.uv && active_mode |=> fault_flags.uv && !outputs_enable;
    endproperty
    a_uv_flag: assert property (p_uv_flag)
        else $error("undervoltage not flagged or outputs on");

    property p_stat_clear;
        @(posedge core_clk) disable iff (rst)
        clr_stat && s.ev_s1 == '0 |=> fault_flags == '0;
    endproperty
    a_stat_clear: assert property (p_stat_clear)
        else $error("status not cleared by reset frame");

    property p_mode;
        @(posedge core_clk) disable iff (rst)
        wr_ctrl |=> active_mode == $past(s.shift_in[23]);
    endproperty
    a_mode: assert property (p_mode)
        else $error("mode bit not taken from frame");

endmodule : rm_recovery_monitor

// file: tb/rm_host_model.sv
module rm_host_model (
    input  wire logic          core_clk,
    input  wire logic          spi_do,
    input  wire logic          spi_do_oe,
    output rm_pkg::rm_spi_in_s spi_in
);
    timeunit 1ns;
    timeprecision 1ps;
    import rm_pkg::*;

    // ****************************************************
    // Mode 0 master, LSB first, 200 ns link period
    // ****************************************************
    initial begin
        spi_in = '{sclk: 1'b0, select_low: 1'b1, di: 1'b0};
    end

    // Link clock rests low between frames; data line is inverted once
    // the frame has ended, so a stale value is never read as valid
    task automatic xfer(input logic [23:0] word,
                        input int          nbits,
                        output logic [23:0] rd);
        rd = '0;
        @(posedge core_clk);
        #1;
        spi_in.select_low = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            spi_in.di = word[i%24];
            #100;
            if (i < 24) begin
                // An undriven data line reads as the inverse
                rd[i] = spi_do_oe ? spi_do : ~spi_do;
            end
            spi_in.sclk = 1'b1;
            #100;
            spi_in.sclk = 1'b0;
        end
        #100;
        spi_in.select_low = 1'b1;
        spi_in.di = ~spi_in.di;
    endtask : xfer
endmodule : rm_host_model

// file: tb/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import rm_pkg::*;

`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    num_errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end

    localparam int STS = 10;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    rm_spi_in_s  spi_in;
    rm_fault_s   fault_in = '0;
    logic        spi_do, spi_do_oe, outputs_enable, active_mode, not_ready;
    rm_mon_sel_e monitor_sel;
    logic        oc_recovery_duty, du;
    rm_fault_s   fault_flags;
    logic [23:0] rd, w;
    int          num_errors = 0, cmp_count = 0, cyc = 0, n;

    always #12.5 core_clk = ~core_clk;

    rm_recovery_monitor #(.STARTUP_CYCLES(STS)) rm_recovery_monitor_i (
        .core_clk        (core_clk),
        .rst             (rst),
        .spi_in          (spi_in),
        .fault_in        (fault_in),
        .spi_do          (spi_do),
        .spi_do_oe       (spi_do_oe),
        .outputs_enable  (outputs_enable),
        .active_mode     (active_mode),
        .not_ready       (not_ready),
        .monitor_sel     (monitor_sel),
        .oc_recovery_duty(oc_recovery_duty),
        .fault_flags     (fault_flags)
    );

    rm_host_model rm_host_model_i (
        .core_clk(core_clk),
        .spi_do  (spi_do),
        .spi_do_oe(spi_do_oe),
        .spi_in  (spi_in)
    );

    // ****************************************************
    // Expectations and helpers
    // ****************************************************
    function automatic logic [23:0] mk(logic en, logic sr, logic [1:0] mon,
                                       logic dis, logic d);
        logic [23:0] v;
        v = 24'($urandom) & 24'h03fffe;
        v[23] = en;
        v[22] = sr;
        v[21] = d;
        v[20] = dis;
        v[19:18] = mon;
        return v;
    endfunction : mk

    function automatic rm_mon_sel_e mon_exp(logic [1:0] m);
        case (m)
            2'h0: return RM_MON_HIGH_SIDE_HEAVY;
            2'h2: return RM_MON_HALF_BRIDGE_ONE;
            2'h1: return RM_MON_HIGH_SIDE_A;
            default: return RM_MON_HIGH_SIDE_B;
        endcase
    endfunction : mon_exp

    task automatic tick(int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask : tick

    task automatic wr(logic [23:0] word);
        rm_host_model_i.xfer(word, 24, rd);
        tick(8);
    endtask : wr

    task automatic done(string s);
        $display("test %s done, mismatches %0d", s, num_errors);
    endtask : done

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            final_report();
        end
    end

    // ****************************************************
    // Tests
    // ****************************************************
    initial begin
        void'($urandom(30480));
        tick(2);
        rst = 1'b0;
        tick(1);
        `CHK("reset do oe", 1'b0, spi_do_oe)
        tick(1);
        `CHK("reset do oe", 1'b0, spi_do_oe)
        tick(2);
        `CHK("reset enable", 1'b0, outputs_enable)
        done("reset");
        rm_host_model_i.xfer(mk(1, 0, 2'h0, 0, 0), 24, rd);
        n = 0;
        while (not_ready !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        n = 0;
        while (not_ready === 1'b1 && n < 100) begin
            `CHK("enable in startup", 1'b0, outputs_enable)
            tick(1);
            n++;
        end
        `CHK("startup cycles", STS, n)
        tick(1);
        `CHK("enable after startup", 1'b1, outputs_enable)
        `CHK("active", 1'b1, active_mode)
        done("startup");
        for (int m = 0; m < 4; m++) begin
            du = 1'($urandom);
            wr(mk(1, 0, 2'(m), 0, du));
            `CHK("monitor", mon_exp(2'(m)), monitor_sel)
            `CHK("duty", du, oc_recovery_duty)
        end
        done("monitor");
        // Short, long and other-register frames leave control as it was
        for (int k = 0; k < 3; k++) begin
            w = mk(1, 0, 2'h0, 0, 0);
            w[0] = (k == 2);
            rm_host_model_i.xfer(w, (k == 0) ? 23 : ((k == 1) ? 25 : 24), rd);
            tick(8);
            `CHK("refused", RM_MON_HIGH_SIDE_B, monitor_sel)
        end
        done("refused");
        fault_in.tw = 1'b1;
        tick(6);
        `CHK("warning flag", 1'b1, fault_flags.tw)
        `CHK("warning keeps on", 1'b1, outputs_enable)
        fault_in.tw = 1'b0;
        wr(mk(1, 0, 2'h3, 0, 0));
        `CHK("warning held", 1'b1, fault_flags.tw)
        `CHK("status word", 24'h880000, rd & 24'hfc0001)
        wr(mk(1, 1, 2'h3, 0, 0));
        `CHK("warning cleared", 4'h0, fault_flags)
        done("warning");
        fault_in.thermal_shutdown_flag = 1'b1;
        tick(6);
        `CHK("shutdown off", 1'b0, outputs_enable)
        fault_in.thermal_shutdown_flag = 1'b0;
        tick(20);
        `CHK("shutdown stays off", 1'b0, outputs_enable)
        wr(mk(1, 1, 2'h3, 0, 0));
        `CHK("shutdown cleared", 1'b1, outputs_enable)
        done("shutdown");
        // Bit 0 of d picks recovery disable, bit 1 overvoltage over under
        for (int d = 0; d < 4; d++) begin
            w = d[1] ? 24'h400000 : 24'h200000;
            wr(mk(1, 0, 2'h0, d[0], 0));
            fault_in = d[1] ? 4'h8 : 4'h4;
            tick(6);
            `CHK("supply flag", w[22:21], {fault_flags.ov, fault_flags.uv})
            `CHK("supply off", 1'b0, outputs_enable)
            fault_in = '0;
            tick(8);
            `CHK("supply recover", ~d[0], outputs_enable)
            wr(mk(1, 1, 2'h0, d[0], 0));
            `CHK("supply status", w | 24'h800000, rd & 24'hfc0001)
            `CHK("supply cleared", 1'b1, outputs_enable)
        end
        done("undervoltage");
        wr(mk(0, 0, 2'h0, 0, 0));
        `CHK("standby", 1'b0, active_mode)
        `CHK("standby off", 1'b0, outputs_enable)
        done("standby");
        final_report();
    end
endmodule : testbench
